// File: shared/cwd_pkg.sv
package cwd_pkg;

	// Byte offsets of the register words on the slave bus.
	localparam logic [4:0] CWD_OFF_CTRL = 5'h00;
	localparam logic [4:0] CWD_OFF_SVC = 5'h04;
	localparam logic [4:0] CWD_OFF_CAUSE = 5'h08;
	localparam logic [4:0] CWD_OFF_STAT = 5'h0c;
	localparam logic [4:0] CWD_OFF_MASK = 5'h10;

	// Field positions inside guard_control_reg.
	localparam int CWD_EN_BIT = 7;
	localparam int CWD_ACT_BIT = 6;
	localparam int CWD_PER_LSB = 3;
	localparam int CWD_BTEN_BIT = 2;
	localparam int CWD_BTDONE_BIT = 1;
	localparam int CWD_IRQF_BIT = 0;

	// Field positions inside the event status and mask words.
	localparam int CWD_STS_TIMEOUT = 0;
	localparam int CWD_STS_TERM = 1;
	localparam int CWD_STS_RESET = 2;

	// Service keys, in the order they must arrive.
	localparam logic [7:0] CWD_KEY_FIRST = 8'h55;
	localparam logic [7:0] CWD_KEY_SECOND = 8'haa;

	// Values after reset.
	localparam logic [2:0] CWD_PER_RST = 3'h0;
	localparam logic [2:0] CWD_EVT_RST = 3'h0;

	// Service sequence progress; a single bit is trivially Gray.
	typedef enum logic [0:0] {
		CWD_SVC_IDLE = 1'b0,
		CWD_SVC_ARMED = 1'b1
	} cwd_svc_e;

	// Last count value of each period, i.e. the period minus one.
	function automatic logic [31:0] cwd_period_limit(input logic [2:0] sel);
		case (sel)
			3'h0: cwd_period_limit = 32'h0000_01ff;
			3'h1: cwd_period_limit = 32'h0000_07ff;
			3'h2: cwd_period_limit = 32'h0000_1fff;
			3'h3: cwd_period_limit = 32'h0000_7fff;
			3'h4: cwd_period_limit = 32'h0007_ffff;
			3'h5: cwd_period_limit = 32'h007f_ffff;
			3'h6: cwd_period_limit = 32'h07ff_ffff;
			default: cwd_period_limit = 32'h7fff_ffff;
		endcase
	endfunction

endpackage

// File: shared/cwd_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
// Link between the register side and the period counter.
interface cwd_cnt_if;
	logic enable;
	logic clear;
	logic [2:0] period_sel;
	logic expired;
	modport ctrl (output enable, output clear, output period_sel, input expired);
	modport cnt (input enable, input clear, input period_sel, output expired);
endinterface
`default_nettype wire

// File: design/cwd_counter.sv
`timescale 1ns/100ps
`default_nettype none
module cwd_counter
	import cwd_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	cwd_cnt_if.cnt cif
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic [31:0] limit;
	logic exp_q;
	logic exp_d;

	// Greater-or-equal rather than equal, so a shorter period chosen mid-count
	// still expires at once instead of wrapping through four billion clocks.
	always_comb begin
		limit = cwd_period_limit(cif.period_sel);
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (cif.clear) begin
			cnt_d = '0;
		end else if (cif.enable) begin
			if (cnt_q >= limit) begin
				cnt_d = '0;
				exp_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end
	end

	// Count and expiry pulse registers.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign cif.expired = exp_q;

	a_clear_restarts: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cif.clear |=> (cnt_q == 32'h0) && !exp_q)
		else $error("Service did not restart the count.");

	a_expire_at_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cif.enable && !cif.clear && cnt_q >= cwd_period_limit(cif.period_sel)) |=> exp_q && cnt_q == 32'h0)
		else $error("Count passed the selected period without expiring.");

	a_idle_holds_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!cif.enable && !cif.clear) |=> $stable(cnt_q) && !exp_q)
		else $error("Counter moved while disabled.");

endmodule
`default_nettype wire

// File: design/cwd_top.sv
`timescale 1ns/100ps
`default_nettype none
module cwd_top
	import cwd_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic irq_ack_i,
	output logic guard_irq_o,
	output logic transfer_ack_o,
	output logic soft_reset_o,
	output logic irq_o
);

	cwd_cnt_if cif();

	// Bus slave state.
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Guard control fields.
	logic enable_q;
	logic enable_d;
	logic action_q;
	logic action_d;
	logic [2:0] period_q;
	logic [2:0] period_d;
	logic bten_q;
	logic bten_d;
	logic btdone_q;
	logic btdone_d;
	logic irqf_q;
	logic irqf_d;

	// Sequence, acknowledge tracking, cause and event registers.
	cwd_svc_e svc_q;
	cwd_svc_e svc_d;
	logic ack_seen_q;
	logic ack_seen_d;
	logic cause_q;
	logic cause_d;
	logic [2:0] sts_q;
	logic [2:0] sts_d;
	logic [2:0] mask_q;
	logic [2:0] mask_d;
	logic irq_q;
	logic irq_d;
	logic tack_q;
	logic tack_d;
	logic srst_q;
	logic srst_d;

	// Decoded accesses.
	logic wr_go;
	logic wr_ctrl;
	logic wr_svc;
	logic wr_cause;
	logic wr_stat;
	logic wr_mask;
	logic [7:0] wbyte;
	logic svc_hit;

	// A write lands only on the edge where the master sees waitrequest low,
	// which is the one edge it is guaranteed to still hold the data.
	assign wr_go = avs_write_i && !wait_q && avs_byteenable_i[0];
	assign wbyte = avs_writedata_i[7:0];
	assign wr_ctrl = wr_go && (avs_address_i == CWD_OFF_CTRL);
	assign wr_svc = wr_go && (avs_address_i == CWD_OFF_SVC);
	assign wr_cause = wr_go && (avs_address_i == CWD_OFF_CAUSE);
	assign wr_stat = wr_go && (avs_address_i == CWD_OFF_STAT);
	assign wr_mask = wr_go && (avs_address_i == CWD_OFF_MASK);
	assign svc_hit = wr_svc && (svc_q == CWD_SVC_ARMED) && (wbyte == CWD_KEY_SECOND);

	// Counter hookup; the counter itself follows the period select live.
	assign cif.enable = enable_q;
	assign cif.period_sel = period_q;
	assign cif.clear = svc_hit;

	// Bus slave: one wait cycle, then the answer with read data preloaded.
	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if ((avs_read_i || avs_write_i) && wait_q) begin
			wait_d = 1'b0;
			rdata_d = '0;
			if (avs_read_i) begin
				case (avs_address_i)
					CWD_OFF_CTRL: rdata_d[7:0] = {enable_q, action_q, period_q, bten_q, btdone_q, irqf_q};
					CWD_OFF_CAUSE: rdata_d[0] = cause_q;
					CWD_OFF_STAT: rdata_d[2:0] = sts_q;
					CWD_OFF_MASK: rdata_d[2:0] = mask_q;
					default: rdata_d = '0;
				endcase
			end
		end
	end

	// Bus slave registers; waitrequest rests high between requests.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
			rdata_q <= '0;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Guard behaviour. Clears are applied first and sets afterwards, so an
	// event in the same cycle as its write-one-clear is kept.
	always_comb begin
		enable_d = enable_q;
		action_d = action_q;
		period_d = period_q;
		bten_d = bten_q;
		btdone_d = btdone_q;
		irqf_d = irqf_q;
		svc_d = svc_q;
		ack_seen_d = ack_seen_q;
		cause_d = cause_q;
		sts_d = sts_q;
		mask_d = mask_q;
		tack_d = 1'b0;
		srst_d = 1'b0;
		if (wr_ctrl) begin
			// Configuration is frozen while a time-out is pending; only the
			// flag bits stay writable so software can clear the pending state.
			if (!irqf_q) begin
				enable_d = wbyte[CWD_EN_BIT];
				action_d = wbyte[CWD_ACT_BIT];
				period_d = wbyte[CWD_PER_LSB +: 3];
				bten_d = wbyte[CWD_BTEN_BIT];
			end
			if (wbyte[CWD_BTDONE_BIT]) begin
				btdone_d = 1'b0;
			end
			if (wbyte[CWD_IRQF_BIT]) begin
				irqf_d = 1'b0;
			end
		end
		if (wr_cause && wbyte[0]) begin
			cause_d = 1'b0;
		end
		if (wr_stat) begin
			sts_d = sts_q & ~wbyte[2:0];
		end
		if (wr_mask) begin
			mask_d = wbyte[2:0];
		end
		// Key sequence; unrelated accesses never touch it.
		if (wr_svc) begin
			case (svc_q)
				CWD_SVC_IDLE: begin
					if (wbyte == CWD_KEY_FIRST) begin
						svc_d = CWD_SVC_ARMED;
					end
				end
				CWD_SVC_ARMED: begin
					if (wbyte == CWD_KEY_FIRST) begin
						svc_d = CWD_SVC_ARMED;
					end else begin
						svc_d = CWD_SVC_IDLE;
					end
				end
				default: svc_d = CWD_SVC_IDLE;
			endcase
		end
		// The core acknowledges the watchdog interrupt.
		if (irqf_q && irq_ack_i) begin
			ack_seen_d = 1'b1;
		end
		// Expiry: first period raises the request, or the guard reset when action is set; a second one while still
		// unacknowledged terminates the stalled bus cycle.
		if (cif.expired) begin
			if (!irqf_q) begin
				if (action_q) begin
					srst_d = 1'b1;
					cause_d = 1'b1;
					sts_d[CWD_STS_RESET] = 1'b1;
				end else begin
					irqf_d = 1'b1;
					ack_seen_d = 1'b0;
					sts_d[CWD_STS_TIMEOUT] = 1'b1;
				end
			end else if (bten_q && !ack_seen_q) begin
				tack_d = 1'b1;
				btdone_d = 1'b1;
				sts_d[CWD_STS_TERM] = 1'b1;
			end
		end
		irq_d = |(sts_d & mask_d);
	end

	// Guard registers; reset leaves the guard disabled, shortest period.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enable_q <= 1'b0;
			action_q <= 1'b0;
			period_q <= CWD_PER_RST;
			bten_q <= 1'b0;
			btdone_q <= 1'b0;
			irqf_q <= 1'b0;
			svc_q <= CWD_SVC_IDLE;
			ack_seen_q <= 1'b0;
			cause_q <= 1'b0;
			sts_q <= CWD_EVT_RST;
			mask_q <= CWD_EVT_RST;
			irq_q <= 1'b0;
			tack_q <= 1'b0;
			srst_q <= 1'b0;
		end else begin
			enable_q <= enable_d;
			action_q <= action_d;
			period_q <= period_d;
			bten_q <= bten_d;
			btdone_q <= btdone_d;
			irqf_q <= irqf_d;
			svc_q <= svc_d;
			ack_seen_q <= ack_seen_d;
			cause_q <= cause_d;
			sts_q <= sts_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			tack_q <= tack_d;
			srst_q <= srst_d;
		end
	end

	cwd_counter u_counter (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.cif(cif)
	);

	// Every output is a flip-flop.
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign guard_irq_o = irqf_q;
	assign transfer_ack_o = tack_q;
	assign soft_reset_o = srst_q;
	assign irq_o = irq_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	a_expiry_needs_enable: assert property (
		cif.expired |-> $past(enable_q))
		else $error("Expiry while the guard was disabled.");

	a_timeout_raises_irq: assert property (
		(cif.expired && !irqf_q && !action_q) |=> guard_irq_o && sts_q[CWD_STS_TIMEOUT])
		else $error("Time-out did not raise the guard interrupt.");

	a_wrong_key_drops: assert property (
		(wr_svc && svc_q == CWD_SVC_ARMED && wbyte != CWD_KEY_SECOND && wbyte != CWD_KEY_FIRST)
		|-> !cif.clear ##1 svc_q == CWD_SVC_IDLE)
		else $error("Wrong second key was not rejected.");

	a_ctrl_locked: assert property (
		(wr_ctrl && irqf_q) |=> $stable(enable_q) && $stable(period_q) && $stable(bten_q) && $stable(action_q))
		else $error("Control changed while a time-out was pending.");

	a_irq_sticky: assert property (
		(irqf_q && !(wr_ctrl && wbyte[CWD_IRQF_BIT])) |=> irqf_q)
		else $error("Guard interrupt withdrawn without a flag clear.");

	a_term_cause: assert property (
		transfer_ack_o |-> $past(cif.expired && irqf_q && bten_q && !ack_seen_q))
		else $error("Transfer acknowledge without a second unacknowledged period.");

	a_term_flag_set: assert property (
		$rose(transfer_ack_o) |-> btdone_q ##1 !transfer_ack_o)
		else $error("Termination flag missing or acknowledge not a pulse.");

	a_reset_cause: assert property (
		soft_reset_o |-> cause_q && !guard_irq_o)
		else $error("Guard reset without its cause flag.");

	a_bus_answer: assert property (
		((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
		else $error("Slave did not answer within one cycle.");

	a_irq_line: assert property (
		(sts_q & mask_q) != 3'h0 |=> irq_o || (sts_q & mask_q) == 3'h0)
		else $error("Interrupt line low with an unmasked event.");

	a_term_sticky: assert property (
		(btdone_q && !(wr_ctrl && wbyte[CWD_BTDONE_BIT])) |=> btdone_q)
		else $error("Termination flag cleared without a one written to it.");

	a_reset_pulse: assert property (
		soft_reset_o |=> !soft_reset_o)
		else $error("Guard reset request longer than one cycle.");

	a_event_to_irq: assert property (
		(cif.expired && !irqf_q && !action_q && mask_q[CWD_STS_TIMEOUT] && !wr_mask) |=> irq_o)
		else $error("Unmasked time-out did not raise the interrupt line.");

endmodule
`default_nettype wire

// File: testbench/cwd_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Stand-in for the core: it answers the guard interrupt a few cycles late, or never while stalled.
module cwd_core_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ack_on_i,
	input wire logic guard_irq_i,
	output logic irq_ack_o
);
	logic [1:0] dly_q;
	// A real core needs a few cycles to reach its acknowledge cycle, so none comes at once.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dly_q <= 2'h0;
			irq_ack_o <= 1'b0;
		end else begin
			dly_q <= (ack_on_i && guard_irq_i) ? dly_q + 2'h1 : 2'h0;
			irq_ack_o <= (dly_q == 2'h3);
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_core_watchdog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_core_watchdog_timer
	import cwd_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic ack_on = 1'b0;
	logic [31:0] rdata;
	logic wreq, irq_ack, girq, tack, sres, irq;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h380b;

	cwd_top u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .irq_ack_i(irq_ack), .guard_irq_o(girq), .transfer_ack_o(tack),
		.soft_reset_o(sres), .irq_o(irq));
	cwd_core_model u_core (.clk_sys_i(clk), .rst_n_i(rst_n), .ack_on_i(ack_on), .guard_irq_i(girq),
		.irq_ack_o(irq_ack));

	// Free-running system clock, 4 ns period.
	initial begin
		forever #2 clk = ~clk;
	end

	// Random source; the sequence is fixed so every run repeats.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected time-out length in clocks for a period code.
	function automatic int per(input logic [2:0] c);
		return (c < 3'h4) ? (1 << (9 + 2 * c)) : (1 << (19 + 4 * (c - 4)));
	endfunction

	task automatic stop_test();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_in(input int n, input int lo, input int hi);
		checks_done++;
		if (n < lo || n > hi) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, n, lo);
		end
	endtask

	// One bus transfer; the request holds until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		wr_en <= w;
		rd_en <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (n >= 20) begin
			err_count++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask

	task automatic svc();
		wr(CWD_OFF_SVC, CWD_KEY_FIRST);
		wr(CWD_OFF_SVC, CWD_KEY_SECOND);
	endtask

	// Counts clocks until the chosen output is seen high; a miss returns the bound.
	task automatic wt(input int s, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (((s == 0) ? girq : (s == 1) ? tack : sres) !== 1'b1 && n < lim);
	endtask

	// Hang guard, well above the longest expected run.
	initial begin
		#400000;
		err_count++;
		stop_test();
	end

	// Main sequence.
	initial begin
		int n;
		logic [7:0] k;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wr(5'h14, seed[7:0]);
		for (int a = 0; a < 6; a++) rdc(5'(a * 4), 32'h0);
		wt(0, 600, n);
		chk_in(n, 600, 600);
		wr(CWD_OFF_MASK, 8'h07);
		wr(CWD_OFF_CTRL, 8'h84);
		be <= 4'he;
		wr(CWD_OFF_CTRL, 8'h00);
		be <= 4'hf;
		rdc(CWD_OFF_CTRL, 32'h84);
		repeat (300) @(posedge clk);
		wr(CWD_OFF_SVC, CWD_KEY_FIRST);
		rdc(5'h14, 32'h0);
		wr(CWD_OFF_SVC, CWD_KEY_SECOND);
		wt(0, 700, n);
		chk_in(n, per(0) - 4, per(0) + 6);
		svc();
		chk(girq, 32'h1);
		wr(CWD_OFF_CTRL, 8'h8c);
		rdc(CWD_OFF_CTRL, 32'h85);
		wt(1, 700, n);
		chk_in(n, per(0) - 50, per(0) + 4);
		rdc(CWD_OFF_CTRL, 32'h87);
		rdc(CWD_OFF_STAT, 32'h3);
		chk(irq, 32'h1);
		wr(CWD_OFF_CTRL, 8'h84);
		rdc(CWD_OFF_CTRL, 32'h87);
		wr(CWD_OFF_MASK, 8'h00);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
		wr(CWD_OFF_STAT, 8'h03);
		rdc(CWD_OFF_STAT, 32'h0);
		wr(CWD_OFF_CTRL, 8'h03);
		rdc(CWD_OFF_CTRL, 32'h84);
		chk(girq, 32'h0);
		wr(CWD_OFF_CTRL, 8'h00);
		wr(CWD_OFF_MASK, 8'h07);
		// A broken key pair must not restart the count; the core now answers promptly.
		ack_on <= 1'b1;
		svc();
		wr(CWD_OFF_CTRL, 8'h84);
		repeat (200) @(posedge clk);
		seed = lfsr_next(seed);
		k = seed[7:0];
		if (k == CWD_KEY_SECOND || k == CWD_KEY_FIRST) k ^= 8'h01;
		wr(CWD_OFF_SVC, CWD_KEY_FIRST);
		wr(CWD_OFF_SVC, k);
		wr(CWD_OFF_SVC, CWD_KEY_SECOND);
		wt(0, 700, n);
		chk_in(n, per(0) - 230, per(0) - 200);
		wt(1, 700, n);
		chk_in(n, 700, 700);
		wr(CWD_OFF_CTRL, 8'h01);
		wr(CWD_OFF_CTRL, 8'h00);
		wr(CWD_OFF_STAT, 8'h07);
		for (int c = 0; c < 3; c++) begin
			svc();
			wr(CWD_OFF_CTRL, 8'h80 | 8'(c << 3));
			wt(0, 9000, n);
			chk_in(n, per(3'(c)) - 4, per(3'(c)) + 6);
			wr(CWD_OFF_CTRL, 8'h01);
			wr(CWD_OFF_CTRL, 8'h00);
		end
		svc();
		wr(CWD_OFF_CTRL, 8'h88);
		repeat (1000) @(posedge clk);
		wr(CWD_OFF_CTRL, 8'h80);
		wt(0, 50, n);
		chk_in(n, 1, 8);
		wr(CWD_OFF_CTRL, 8'h01);
		wr(CWD_OFF_CTRL, 8'h00);
		wr(CWD_OFF_STAT, 8'h07);
		svc();
		wr(CWD_OFF_CTRL, 8'hc0);
		wt(2, 700, n);
		chk_in(n, per(0) - 4, per(0) + 6);
		chk(girq, 32'h0);
		wr(CWD_OFF_CTRL, 8'h00);
		rdc(CWD_OFF_CAUSE, 32'h1);
		rdc(CWD_OFF_STAT, 32'h4);
		chk(irq, 32'h1);
		wr(CWD_OFF_CAUSE, 8'h01);
		rdc(CWD_OFF_CAUSE, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
